// ---- src/pcfg_map.svh ----
// offsets, field positions, fixed values and timing counts of the config header
`ifndef PCFG_MAP_SVH
`define PCFG_MAP_SVH

`define PCFG_DW_ID       6'h00
`define PCFG_DW_CMD      6'h01
`define PCFG_DW_CLASS    6'h02
`define PCFG_DW_MISC     6'h03
`define PCFG_DW_SERIAL_PORT_WINDOW_BASE     6'h04
`define PCFG_DW_OPTION_WINDOW_BASE     6'h05
`define PCFG_DW_SUBSYS   6'h0b
`define PCFG_DW_CAPPTR   6'h0d
`define PCFG_DW_PM       6'h10

`define PCFG_CMD_IO      0
`define PCFG_CMD_MEM     1
`define PCFG_CMD_PERR    6
`define PCFG_CMD_SERR    8
`define PCFG_CMD_INTXD   10

`define PCFG_ST_INTX     3
`define PCFG_ST_CAPL     4
`define PCFG_ST_MDPE     8
`define PCFG_ST_STA      11
`define PCFG_ST_RTA      12
`define PCFG_ST_RMA      13
`define PCFG_ST_SSE      14
`define PCFG_ST_DPE      15

`define PCFG_CLASS_CODE  24'h070002
`define PCFG_HDR_TYPE    8'h00
`define PCFG_LAT_TIMER   8'h00
`define PCFG_SELF_TEST_CONTROL_CAP    1'b1
`define PCFG_SELF_TEST_CONTROL_START  6
`define PCFG_SELF_TEST_CONTROL_PASS   4'h0
`define PCFG_CAP_PTR     8'h40
`define PCFG_PM_ID       8'h01
`define PCFG_PM_NEXT     8'h48
`define PCFG_PM_CAPS     16'hc9e3
`define PCFG_WIN0_BITS   7
`define PCFG_WIN1_BITS   5
`define PCFG_SELF_TEST_CONTROL_NS     2000
`define PCFG_CLK_NS      50
`define PCFG_SELF_TEST_CONTROL_CYCLES (`PCFG_SELF_TEST_CONTROL_NS / `PCFG_CLK_NS)

`endif

// ---- src/pcfg_pkg.sv ----
// types of the config header block
package pcfg_pkg;

  typedef struct packed {
    logic        intx_dis;
    logic        serr_en;
    logic        perr_en;
    logic        mem_en;
    logic        io_en;
    logic        dpe;
    logic        sse;
    logic        rma;
    logic        rta;
    logic        sta;
    logic        mdpe;
    logic        intx_sent;
    logic [7:0]  cls;
    logic [24:0] serial_port_window_base;
    logic [26:0] option_window_base;
    logic        strap_io;
    logic        strap_pend;
    logic        self_test_control_run;
    logic [7:0]  self_test_control_cnt;
    logic [31:0] rdata;
    logic        ack;
    logic        hit0;
    logic        hit1;
    logic        ur;
    logic        intx_assert;
    logic        intx_deassert;
    logic        fatal_msg;
    logic        nonfatal_msg;
  } pcfg_state_t;

endpackage : pcfg_pkg

// ---- src/pcfg_config_header.sv ----
// type-0 configuration header of the serial-port endpoint
`timescale 1ns/1ps
// What this block does
// - command bit 10 inhibits legacy assert messages
// - pending assert still gets its deassert
// - command bit 8 gates error message reporting
// - command bits 9,7,5,4,3 read zero
// - bus-master bit 2 reads zero always
// - memory enable off gives unsupported request
// - io enable off gives unsupported request
// - status 15 sets only on rx_poisoned_in, not on rx_poison_cpl_in or tx_poison_wr_in
// - status 14 sets on sent error message
// - status 13,12,11 track abort completions
// - status 8 needs parity response enable
// - status 4 reads one, legacy bits zero
// - status 3 shows outstanding legacy interrupt
// - class code reads 07_00_02h
// - cache line size stored, no effect
// - latency timer always reads zero
// - header type reads 00h single function
// - self-test start bit clears on completion
// - strap picks memory or io windows
// - window sizes 80h and 20h bytes
// - power power_capability_identifier 01h, next 48h
// - power event support field reads 11001b
`include "pcfg_map.svh"

module pcfg_config_header #(
  parameter logic [15:0] VENDOR_CODE = 16'h0a5a, // arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h0001, // arbitrary value
  parameter logic [7:0]  REV_CODE    = 8'h01,    // arbitrary value
  parameter int          SELF_TEST_CONTROL_CYCLES = `PCFG_SELF_TEST_CONTROL_CYCLES
) (
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // configuration requests
  input  wire logic        cfg_req_in,
  input  wire logic        cfg_we_in,
  input  wire logic [5:0]  cfg_dw_in,
  input  wire logic [3:0]  cfg_be_in,
  input  wire logic [31:0] cfg_wdata_in,
  output logic [31:0]      cfg_rdata_out,
  output logic             cfg_ack_out,
  // incoming memory and io requests
  input  wire logic        req_valid_in,
  input  wire logic        req_io_in,
  input  wire logic [31:0] req_addr_in,
  output logic             hit_serial_out,
  output logic             hit_option_out,
  output logic             req_ur_out,
  // strap
  input  wire logic        window_space_select_strap_in,
  // legacy interrupt
  input  wire logic        intx_req_in,
  output logic             intx_assert_msg_out,
  output logic             intx_deassert_msg_out,
  // error detection and reporting
  input  wire logic        err_fatal_det_in,
  input  wire logic        err_nonfatal_det_in,
  input  wire logic        devctl_fatal_en_in,
  input  wire logic        devctl_nonfatal_en_in,
  output logic             err_fatal_msg_out,
  output logic             err_nonfatal_msg_out,
  // transaction events
  input  wire logic        rx_poisoned_in,
  input  wire logic        rx_poison_cpl_in,
  input  wire logic        tx_poison_wr_in,
  input  wire logic        rx_ur_cpl_in,
  input  wire logic        rx_ca_cpl_in,
  input  wire logic        tx_ca_cpl_in
);

  pcfg_pkg::pcfg_state_t q_ff;
  pcfg_pkg::pcfg_state_t nxt_q;

  logic [15:0] cmd_val;
  logic [15:0] stat_val;
  logic [31:0] rd_val;
  logic        wr;
  logic        intx_want;

  always_comb
  begin
    cmd_val = 16'h0000;
    cmd_val[`PCFG_CMD_INTXD] = q_ff.intx_dis;
    cmd_val[`PCFG_CMD_SERR]  = q_ff.serr_en;
    cmd_val[`PCFG_CMD_PERR]  = q_ff.perr_en;
    cmd_val[`PCFG_CMD_MEM]   = q_ff.mem_en;
    cmd_val[`PCFG_CMD_IO]    = q_ff.io_en;
    stat_val = 16'h0000;
    stat_val[`PCFG_ST_DPE]  = q_ff.dpe;
    stat_val[`PCFG_ST_SSE]  = q_ff.sse;
    stat_val[`PCFG_ST_RMA]  = q_ff.rma;
    stat_val[`PCFG_ST_RTA]  = q_ff.rta;
    stat_val[`PCFG_ST_STA]  = q_ff.sta;
    stat_val[`PCFG_ST_MDPE] = q_ff.mdpe;
    stat_val[`PCFG_ST_CAPL] = 1'b1;
    stat_val[`PCFG_ST_INTX] = q_ff.intx_sent;
  end

  always_comb
  begin
    rd_val = 32'h0000_0000;
    unique case (cfg_dw_in)
      `PCFG_DW_ID:     rd_val = {DEVICE_CODE, VENDOR_CODE};
      `PCFG_DW_CMD:    rd_val = {stat_val, cmd_val};
      `PCFG_DW_CLASS:  rd_val = {`PCFG_CLASS_CODE, REV_CODE};
      `PCFG_DW_MISC:   rd_val = {`PCFG_SELF_TEST_CONTROL_CAP, q_ff.self_test_control_run, 2'b00, `PCFG_SELF_TEST_CONTROL_PASS,
                                 `PCFG_HDR_TYPE, `PCFG_LAT_TIMER, q_ff.cls};
      `PCFG_DW_SERIAL_PORT_WINDOW_BASE:   rd_val = {q_ff.serial_port_window_base, 6'h00, q_ff.strap_io};
      `PCFG_DW_OPTION_WINDOW_BASE:   rd_val = {q_ff.option_window_base, 4'h0, q_ff.strap_io};
      `PCFG_DW_SUBSYS: rd_val = {DEVICE_CODE, VENDOR_CODE};
      `PCFG_DW_CAPPTR: rd_val = {24'h000000, `PCFG_CAP_PTR};
      `PCFG_DW_PM:     rd_val = {`PCFG_PM_CAPS, `PCFG_PM_NEXT, `PCFG_PM_ID};
      default:         rd_val = 32'h0000_0000;
    endcase
  end

  assign wr        = cfg_req_in & cfg_we_in;
  // inhibit also withdraws a pending interrupt
  assign intx_want = intx_req_in & ~q_ff.intx_dis;

  always_comb
  begin
    nxt_q = q_ff;
    nxt_q.ack           = cfg_req_in;
    nxt_q.rdata         = (cfg_req_in & ~cfg_we_in) ? rd_val : 32'h0000_0000;
    nxt_q.intx_assert   = 1'b0;
    nxt_q.intx_deassert = 1'b0;

    // strap caught on the first cycle after reset release
    if (q_ff.strap_pend)
    begin
      nxt_q.strap_io   = window_space_select_strap_in;
      nxt_q.strap_pend = 1'b0;
    end

    // command, cache line, windows
    if (wr && cfg_dw_in == `PCFG_DW_CMD)
    begin
      if (cfg_be_in[0])
      begin
        nxt_q.io_en   = cfg_wdata_in[`PCFG_CMD_IO];
        nxt_q.mem_en  = cfg_wdata_in[`PCFG_CMD_MEM];
        nxt_q.perr_en = cfg_wdata_in[`PCFG_CMD_PERR];
      end
      if (cfg_be_in[1])
      begin
        nxt_q.serr_en  = cfg_wdata_in[`PCFG_CMD_SERR];
        nxt_q.intx_dis = cfg_wdata_in[`PCFG_CMD_INTXD];
      end
    end
    if (wr && cfg_dw_in == `PCFG_DW_MISC && cfg_be_in[0])
      nxt_q.cls = cfg_wdata_in[7:0];
    if (wr && cfg_dw_in == `PCFG_DW_SERIAL_PORT_WINDOW_BASE)
    begin
      if (cfg_be_in[0])
        nxt_q.serial_port_window_base[0] = cfg_wdata_in[7];
      if (cfg_be_in[1])
        nxt_q.serial_port_window_base[8:1] = cfg_wdata_in[15:8];
      if (cfg_be_in[2])
        nxt_q.serial_port_window_base[16:9] = cfg_wdata_in[23:16];
      if (cfg_be_in[3])
        nxt_q.serial_port_window_base[24:17] = cfg_wdata_in[31:24];
    end
    if (wr && cfg_dw_in == `PCFG_DW_OPTION_WINDOW_BASE)
    begin
      if (cfg_be_in[0])
        nxt_q.option_window_base[2:0] = cfg_wdata_in[7:5];
      if (cfg_be_in[1])
        nxt_q.option_window_base[10:3] = cfg_wdata_in[15:8];
      if (cfg_be_in[2])
        nxt_q.option_window_base[18:11] = cfg_wdata_in[23:16];
      if (cfg_be_in[3])
        nxt_q.option_window_base[26:19] = cfg_wdata_in[31:24];
    end

    // self-test: start bit stays high until the run ends
    if (q_ff.self_test_control_run)
    begin
      nxt_q.self_test_control_cnt = q_ff.self_test_control_cnt + 8'h01;
      if (q_ff.self_test_control_cnt == 8'(SELF_TEST_CONTROL_CYCLES - 1))
      begin
        nxt_q.self_test_control_run = 1'b0;
        nxt_q.self_test_control_cnt = 8'h00;
      end
    end
    else if (wr && cfg_dw_in == `PCFG_DW_MISC && cfg_be_in[3] && cfg_wdata_in[24 + `PCFG_SELF_TEST_CONTROL_START])
      nxt_q.self_test_control_run = 1'b1;

    // status clears first, so a same-cycle event still sets
    if (wr && cfg_dw_in == `PCFG_DW_CMD)
    begin
      if (cfg_be_in[3])
      begin
        if (cfg_wdata_in[16 + `PCFG_ST_DPE])
          nxt_q.dpe = 1'b0;
        if (cfg_wdata_in[16 + `PCFG_ST_SSE])
          nxt_q.sse = 1'b0;
        if (cfg_wdata_in[16 + `PCFG_ST_RMA])
          nxt_q.rma = 1'b0;
        if (cfg_wdata_in[16 + `PCFG_ST_RTA])
          nxt_q.rta = 1'b0;
        if (cfg_wdata_in[16 + `PCFG_ST_STA])
          nxt_q.sta = 1'b0;
      end
      // status bit 8 sits in the top byte, so lane 3 carries it
      if (cfg_be_in[3] && cfg_wdata_in[16 + `PCFG_ST_MDPE])
        nxt_q.mdpe = 1'b0;
    end

    // error messages follow both enables
    nxt_q.fatal_msg    = err_fatal_det_in & q_ff.serr_en & devctl_fatal_en_in;
    nxt_q.nonfatal_msg = err_nonfatal_det_in & q_ff.serr_en & devctl_nonfatal_en_in;
    if (nxt_q.fatal_msg | nxt_q.nonfatal_msg)
      nxt_q.sse = 1'b1;
    if (rx_poisoned_in)
      nxt_q.dpe = 1'b1;
    if (rx_ur_cpl_in)
      nxt_q.rma = 1'b1;
    if (rx_ca_cpl_in)
      nxt_q.rta = 1'b1;
    if (tx_ca_cpl_in)
      nxt_q.sta = 1'b1;
    if (q_ff.perr_en && (rx_poison_cpl_in || tx_poison_wr_in))
      nxt_q.mdpe = 1'b1;

    // one assert, then exactly one deassert
    if (!q_ff.intx_sent && intx_want)
    begin
      nxt_q.intx_sent   = 1'b1;
      nxt_q.intx_assert = 1'b1;
    end
    else if (q_ff.intx_sent && !intx_want)
    begin
      nxt_q.intx_sent     = 1'b0;
      nxt_q.intx_deassert = 1'b1;
    end

    // window decode; mismatched space or disabled decoder is unsupported
    nxt_q.hit0 = req_valid_in && (req_io_in == q_ff.strap_io)
                 && (req_io_in ? q_ff.io_en : q_ff.mem_en)
                 && req_addr_in[31:`PCFG_WIN0_BITS] == q_ff.serial_port_window_base;
    nxt_q.hit1 = req_valid_in && (req_io_in == q_ff.strap_io)
                 && (req_io_in ? q_ff.io_en : q_ff.mem_en)
                 && req_addr_in[31:`PCFG_WIN1_BITS] == q_ff.option_window_base;
    nxt_q.ur   = req_valid_in & ~nxt_q.hit0 & ~nxt_q.hit1;

    if (rst_in)
    begin
      nxt_q            = '0;
      nxt_q.strap_pend = 1'b1;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    q_ff <= nxt_q;
  end

  assign cfg_rdata_out         = q_ff.rdata;
  assign cfg_ack_out           = q_ff.ack;
  assign hit_serial_out        = q_ff.hit0;
  assign hit_option_out        = q_ff.hit1;
  assign req_ur_out            = q_ff.ur;
  assign intx_assert_msg_out   = q_ff.intx_assert;
  assign intx_deassert_msg_out = q_ff.intx_deassert;
  assign err_fatal_msg_out     = q_ff.fatal_msg;
  assign err_nonfatal_msg_out  = q_ff.nonfatal_msg;

endmodule : pcfg_config_header

// ---- sim/pcfg_checker_assertions.sv ----
// port checker of the config header
`timescale 1ns/1ps
module pcfg_checker (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rst_in,
  // decode and legacy interrupt
  input wire logic req_valid_in,
  input wire logic hit_serial_out,
  input wire logic hit_option_out,
  input wire logic req_ur_out,
  input wire logic intx_req_in,
  input wire logic intx_assert_msg_out,
  input wire logic intx_deassert_msg_out
);
  logic pend_ff;
  logic any;
  assign any = hit_serial_out | hit_option_out | req_ur_out;
  // outstanding assert, seen only through the message pulses
  always_ff @(posedge mclk_in)
    pend_ff <= !rst_in & (pend_ff | intx_assert_msg_out) & !intx_deassert_msg_out;
  default clocking @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);
  dec_answer_a: assert property (
    req_valid_in |=> any) else $error("decode silent");
  dec_quiet_a: assert property (
    !req_valid_in |=> !any) else $error("stray decode answer");
  ur_alone_a: assert property (
    req_ur_out |-> !hit_serial_out && !hit_option_out) else $error("refusal with hit");
  intx_cause_a: assert property (
    intx_assert_msg_out |-> $past(intx_req_in)) else $error("assert unrequested");
  intx_alt_a: assert property (
    intx_assert_msg_out |-> !pend_ff ##1 !intx_assert_msg_out) else $error("assert repeated");
  intx_pair_a: assert property (
    intx_deassert_msg_out |-> pend_ff && !intx_assert_msg_out) else $error("deassert unpaired");
  intx_drop_a: assert property (
    $fell(intx_req_in) && !intx_deassert_msg_out && (pend_ff || intx_assert_msg_out)
    |=> intx_deassert_msg_out) else $error("no deassert");
  reset_quiet_a: assert property (
    $fell(rst_in) |-> !any && !intx_assert_msg_out) else $error("output after reset");
endmodule : pcfg_checker

bind pcfg_config_header pcfg_checker u_chk (.mclk_in(mclk_in), .rst_in(rst_in), .req_valid_in(req_valid_in),
  .hit_serial_out(hit_serial_out), .hit_option_out(hit_option_out), .req_ur_out(req_ur_out),
  .intx_req_in(intx_req_in), .intx_assert_msg_out(intx_assert_msg_out),
  .intx_deassert_msg_out(intx_deassert_msg_out));

// ---- sim/pcfg_root_model.sv ----
// root complex model issuing configuration requests
`timescale 1ns/1ps
module pcfg_root_model (
  // clock and answer
  input  wire logic        mclk_in,
  input  wire logic [31:0] cfg_rdata_in,
  input  wire logic        cfg_ack_in,
  // request
  output logic             cfg_req_out,
  output logic             cfg_we_out,
  output logic [5:0]       cfg_dw_out,
  output logic [3:0]       cfg_be_out,
  output logic [31:0]      cfg_wdata_out
);
  logic        req_ff = 1'b0;
  logic [42:0] qual_ff = '0;
  assign cfg_req_out = req_ff;
  assign {cfg_we_out, cfg_dw_out, cfg_be_out, cfg_wdata_out} = qual_ff;
  // released lines show the inverse, so stale values never pass
  task automatic access(input logic [42:0] q, output logic [31:0] r);
    @(posedge mclk_in);
    req_ff <= 1'b1;
    qual_ff <= q; // ones in the data clear status
    @(posedge mclk_in);
    req_ff <= 1'b0;
    qual_ff <= ~q;
    @(posedge mclk_in);
    r = (cfg_ack_in === 1'b1) ? cfg_rdata_in : 'x;
  endtask : access
endmodule : pcfg_root_model

// ---- sim/testbench.sv ----
// self-checking bench of the config header
`timescale 1ns/1ps
module testbench;
  logic        mclk = 1'b0, rst = 1'b1, strap = 1'b0, rv = 1'b0, rio = 1'b0, intx = 1'b0;
  logic        req, we, ack, hs, ho, ur, ias, ids, efm, enm;
  logic        dfe = 1'b1, dne = 1'b1;
  logic [3:0]  be;
  logic [5:0]  dw;
  logic [7:0]  ev = '0;
  logic [31:0] raddr = '0, rd, rdata, wd;
  int          n_errors = 0, comparisons = 0, n_as = 0, n_ds = 0, cyc = 0, n_fm = 0, n_nm = 0;

  initial forever #25 mclk = ~mclk;

  pcfg_config_header #(.SELF_TEST_CONTROL_CYCLES(8)) dut (.mclk_in(mclk), .rst_in(rst), .cfg_req_in(req), .cfg_we_in(we),
    .cfg_dw_in(dw), .cfg_be_in(be), .cfg_wdata_in(wd), .cfg_rdata_out(rdata), .cfg_ack_out(ack),
    .req_valid_in(rv), .req_io_in(rio), .req_addr_in(raddr), .hit_serial_out(hs), .hit_option_out(ho),
    .req_ur_out(ur), .window_space_select_strap_in(strap), .intx_req_in(intx), .intx_assert_msg_out(ias),
    .intx_deassert_msg_out(ids), .err_fatal_det_in(ev[7]), .err_nonfatal_det_in(ev[6]),
    .devctl_fatal_en_in(dfe), .devctl_nonfatal_en_in(dne), .err_fatal_msg_out(efm), .err_nonfatal_msg_out(enm),
    .rx_poisoned_in(ev[5]), .rx_poison_cpl_in(ev[4]), .tx_poison_wr_in(ev[3]), .rx_ur_cpl_in(ev[2]),
    .rx_ca_cpl_in(ev[1]), .tx_ca_cpl_in(ev[0]));

  pcfg_root_model root (.mclk_in(mclk), .cfg_rdata_in(rdata), .cfg_ack_in(ack), .cfg_req_out(req),
    .cfg_we_out(we), .cfg_dw_out(dw), .cfg_be_out(be), .cfg_wdata_out(wd));

  always @(posedge mclk)
  begin
    n_as <= n_as + (ias === 1'b1);
    n_ds <= n_ds + (ids === 1'b1);
    n_fm <= n_fm + (efm === 1'b1);
    n_nm <= n_nm + (enm === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [5:0] d, input logic [3:0] b, input logic [31:0] v);
    root.access({1'b1, d, b, v}, rd);
  endtask : wr

  task automatic rdc(input string nm, input logic [5:0] d, input logic [31:0] m, input logic [31:0] e);
    root.access({1'b0, d, 4'hf, 32'h0}, rd);
    chk(nm, rd & m, e);
  endtask : rdc

  // one-cycle event or request, then one edge for the registered answer
  task automatic strobe(input logic [7:0] e, input logic v, input logic io, input logic [31:0] a);
    @(posedge mclk);
    ev <= e;
    rv <= v;
    rio <= io;
    raddr <= a;
    @(posedge mclk);
    ev <= 8'h00;
    rv <= 1'b0;
    raddr <= ~a;
    @(posedge mclk);
  endtask : strobe

  task automatic dreq(input logic io, input logic [31:0] a, input logic [2:0] e);
    strobe(8'h00, 1'b1, io, a);
    chk("decode", {29'h0, hs, ho, ur}, {29'h0, e});
  endtask : dreq

  task automatic t_fixed;
    rdc("status", 6'h01, 32'hffff_ffff, 32'h0010_0000);
    rdc("class", 6'h02, 32'hffff_ff00, 32'h0700_0200);
    wr(6'h03, 4'hf, 32'h3fff_ff5a);
    rdc("misc", 6'h03, 32'hffff_ffff, 32'h8000_005a);
    rdc("pm cap", 6'h10, 32'hffff_ffff, 32'hc9e3_4801);
    rdc("cap pointer", 6'h0d, 32'hffff_ffff, 32'h0000_0040);
    rdc("unmapped", 6'h3f, 32'hffff_ffff, 32'h0);
    wr(6'h01, 4'h3, 32'h0000_ffff);
    rdc("command", 6'h01, 32'h0000_ffff, 32'h0000_0543);
  endtask : t_fixed

  task automatic t_status;
    wr(6'h01, 4'h3, 32'h0000_0140);
    strobe(8'hff, 1'b0, 1'b0, 32'h0);
    rdc("status set", 6'h01, 32'hffff_0000, 32'hf910_0000);
    chk("fatal msgs", 32'(n_fm), 32'd1);
    chk("nonfatal msgs", 32'(n_nm), 32'd1);
    wr(6'h01, 4'hc, 32'h0000_0140);
    rdc("status kept", 6'h01, 32'hffff_0000, 32'hf910_0000);
    // top lane alone must clear every sticky bit, bit 8 included
    wr(6'h01, 4'h8, 32'hffff_0000);
    rdc("status clear", 6'h01, 32'hffff_0000, 32'h0010_0000);
    dfe <= 1'b0;
    strobe(8'hc4, 1'b0, 1'b0, 32'h0);
    dfe <= 1'b1;
    dne <= 1'b0;
    strobe(8'hc0, 1'b0, 1'b0, 32'h0);
    dne <= 1'b1;
    rdc("one report", 6'h01, 32'hffff_0000, 32'h6010_0000);
    chk("fatal sent", 32'(n_fm), 32'd2);
    chk("nonfatal sent", 32'(n_nm), 32'd2);
    wr(6'h01, 4'hf, 32'hffff_0000);
    strobe(8'hd8, 1'b0, 1'b0, 32'h0);
    rdc("gated", 6'h01, 32'h4100_0000, 32'h0);
    chk("gated msgs", 32'(n_fm + n_nm), 32'd4);
  endtask : t_status

  task automatic t_intx;
    intx <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("asserts", 32'(n_as), 32'd1);
    rdc("pending", 6'h01, 32'h0008_0000, 32'h0008_0000);
    wr(6'h01, 4'h3, 32'h0000_0400);
    repeat (2) @(posedge mclk);
    chk("deasserts", 32'(n_ds), 32'd1);
    rdc("closed", 6'h01, 32'h0008_0000, 32'h0);
    chk("inhibited", 32'(n_as), 32'd1);
    intx <= 1'b0;
  endtask : t_intx

  task automatic t_self_test_control;
    wr(6'h03, 4'h8, 32'h4000_0000);
    rdc("self_test_control run", 6'h03, 32'h4000_0000, 32'h4000_0000);
    repeat (10) @(posedge mclk);
    rdc("self_test_control done", 6'h03, 32'hcf00_0000, 32'h8000_0000);
  endtask : t_self_test_control

  task automatic t_decode;
    wr(6'h04, 4'hf, 32'hffff_ffff);
    rdc("window0", 6'h04, 32'hffff_ffff, 32'hffff_ff80);
    wr(6'h05, 4'hf, 32'hffff_ffff);
    rdc("window1", 6'h05, 32'hffff_ffff, 32'hffff_ffe0);
    wr(6'h04, 4'hf, 32'h1000_0000);
    wr(6'h05, 4'hf, 32'h2000_0000);
    wr(6'h01, 4'h3, 32'h0000_0002);
    dreq(1'b0, 32'h1000_007f, 3'b100);
    dreq(1'b0, 32'h1000_0080, 3'b001);
    dreq(1'b0, 32'h2000_001f, 3'b010);
    dreq(1'b1, 32'h1000_0000, 3'b001);
    wr(6'h01, 4'h3, 32'h0);
    dreq(1'b0, 32'h1000_0000, 3'b001);
  endtask : t_decode

  task automatic t_io;
    wr(6'h01, 4'h3, 32'h0000_ffff);
    strobe(8'h20, 1'b0, 1'b0, 32'h0);
    rst <= 1'b1;
    strap <= 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rdc("after reset", 6'h01, 32'hffff_ffff, 32'h0010_0000);
    rdc("io window", 6'h04, 32'hffff_ffff, 32'h0000_0001);
    wr(6'h04, 4'hf, 32'h0000_1000);
    wr(6'h01, 4'h3, 32'h0000_0001);
    dreq(1'b1, 32'h0000_1010, 3'b100);
    dreq(1'b0, 32'h0000_1010, 3'b001);
    wr(6'h01, 4'h3, 32'h0);
    dreq(1'b1, 32'h0000_1010, 3'b001);
  endtask : t_io

  initial
  begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_fixed();
    t_status();
    t_intx();
    t_self_test_control();
    t_decode();
    t_io();
    print_verdict();
  end
endmodule : testbench
